//--- hw/aps_defines.svh
/*
  Register offsets, field positions, depths and reset values for the
  point-list sequencer. Assumes it is included by bare name.
*/
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH

// Register offsets on the host I/O port
`define APS_OFS_RESULT_LO 3'h0
`define APS_OFS_RESULT_HI 3'h1
`define APS_OFS_POINT_LIST 3'h2
`define APS_OFS_OPTION 3'h4

// Option control bit positions
`define APS_OPT_EXT_EN 7
`define APS_OPT_PL_CLR 6
`define APS_OPT_DF_CLR 3
`define APS_OPT_HALF_IE 2
`define APS_OPT_ERR_IE 1
`define APS_OPT_PACED 0
`define APS_OPT_RESET 8'h00

// Status bit positions
`define APS_ST_BUSY 7
`define APS_ST_PL_FULL 6
`define APS_ST_PL_HALF 5
`define APS_ST_PL_EMPTY 4
`define APS_ST_DF_FULL 3
`define APS_ST_DF_HALF 2
`define APS_ST_DF_EMPTY 1
`define APS_ST_EXT 0

// Point-list entry fields
`define APS_ENT_CH_HI 7
`define APS_ENT_CH_LO 4
`define APS_ENT_DIFFERENTIAL_SELECT 3
`define APS_ENT_RANGE_HI 2
`define APS_ENT_RANGE_LO 0
`define APS_ENT_TAG_HI 15
`define APS_ENT_TAG_LO 12
`define APS_ENT_GAIN_HI 10
`define APS_ENT_GAIN_LO 8

// Sizes
`define APS_RESULT_BITS 12
`define APS_PL_DEPTH 2048
`define APS_DF_DEPTH 1024

`endif

//--- hw/aps_pkg.sv
/*
  Types shared by the point-list sequencer files.
  Assumes nothing of its surroundings.
*/
package aps_pkg;

  // Conversion sequencer states, one-hot
  typedef enum logic [1:0] {
    APS_IDLE = 2'b01,
    APS_CONV = 2'b10
  } aps_state_e;

endpackage

//--- hw/aps_fifo.sv
/*
  Synchronous FIFO with clear, fill count and full, half and empty flags.
  Assumes nothing of push and pop; push while full and pop while empty are ignored.
*/
`timescale 1ns/1ps
module aps_fifo
  import aps_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 1024
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic half,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two, at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("aps_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_push;
  logic do_pop;

  // Flags and head word
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rd_ptr_ff];
  assign full = (count_ff == (AW+1)'(DEPTH));
  assign half = (count_ff >= (AW+1)'(DEPTH / 2));
  assign empty = (count_ff == '0);

  // Storage array
  always_ff @(posedge clk)
  begin
    if (ce && do_push)
      mem[wr_ptr_ff] <= wdata;
  end

  // Pointers and fill count; clear discards everything
  always_ff @(posedge clk)
  begin
    if (rst || (ce && clr))
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else if (ce)
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(do_push);
      rd_ptr_ff <= rd_ptr_ff + AW'(do_pop);
      count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

//--- hw/aps_sequencer.sv
/*
  Point-list conversion sequencer with tagged result FIFO, option
  control, active-low status flags except the start pin bit, and interrupt request.
  Assumes host I/O strobes, the pacing pulse and the converter's done
  strobe come from logic on ref_clk; the start pin is asynchronous.
*/
`timescale 1ns/1ps
`include "aps_defines.svh"

module aps_sequencer
  import aps_pkg::*;
#(
  parameter int PL_DEPTH = `APS_PL_DEPTH,
  parameter int DF_DEPTH = `APS_DF_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic io_word,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic irq,
  input wire logic pace_pulse,
  input wire logic ext_start_pin,
  input wire logic adc_done,
  input wire logic [`APS_RESULT_BITS-1:0] adc_data,
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic adc_differential_select,
  output logic [2:0] adc_range,
  output logic [3:0] submux_tag,
  output logic [2:0] submux_gain
);
  localparam int PAW = $clog2(PL_DEPTH);

  // Point-list depth must be a power of two
  if (PL_DEPTH < 2 || (1 << PAW) != PL_DEPTH)
  begin : g_bad_pl_depth
    $error("aps_sequencer: PL_DEPTH must be a power of two");
  end

  // Point-list storage and state
  logic [15:0] pl_mem [PL_DEPTH];
  logic [PAW:0] pl_count_ff;
  logic [PAW-1:0] scan_ff;
  logic pl_armed_ff;
  aps_state_e state_ff;
  logic [7:0] opt_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;
  logic start_ff;
  logic [3:0] chan_ff;
  logic differential_select_ff;
  logic [2:0] range_ff;
  logic [3:0] tag_ff;
  logic [2:0] gain_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;

  // Host access decode
  logic wr_start;
  logic wr_pl;
  logic wr_opt;
  logic rd_lo;
  logic rd_hi;
  logic rd_pl;
  logic rd_stat;
  assign wr_start = io_wr && io_addr == `APS_OFS_RESULT_LO;
  assign wr_pl = io_wr && io_word && io_addr == `APS_OFS_POINT_LIST;
  assign wr_opt = io_wr && io_addr == `APS_OFS_OPTION;
  assign rd_lo = io_rd && io_addr == `APS_OFS_RESULT_LO;
  assign rd_hi = io_rd && !io_word && io_addr == `APS_OFS_RESULT_HI;
  assign rd_pl = io_rd && io_word && io_addr == `APS_OFS_POINT_LIST;
  assign rd_stat = io_rd && io_addr == `APS_OFS_OPTION;

  // Option fields and clear strobes
  logic pl_clr;
  logic df_clr;
  logic opt_ext_en;
  logic opt_half_ie;
  logic opt_err_ie;
  logic opt_paced;
  assign pl_clr = wr_opt && io_wdata[`APS_OPT_PL_CLR];
  assign df_clr = wr_opt && io_wdata[`APS_OPT_DF_CLR];
  assign opt_ext_en = opt_ff[`APS_OPT_EXT_EN];
  assign opt_half_ie = opt_ff[`APS_OPT_HALF_IE];
  assign opt_err_ie = opt_ff[`APS_OPT_ERR_IE];
  assign opt_paced = opt_ff[`APS_OPT_PACED];

  // Point-list flags and entry for the next conversion
  logic pl_full;
  logic pl_half;
  logic pl_empty;
  logic [15:0] cur_entry;
  logic [PAW-1:0] scan_next;
  assign pl_full = (pl_count_ff == (PAW+1)'(PL_DEPTH));
  assign pl_half = (pl_count_ff >= (PAW+1)'(PL_DEPTH / 2));
  assign pl_empty = (pl_count_ff == '0);
  assign cur_entry = pl_empty ? 16'h0000 : pl_mem[scan_ff];
  // Wrap to the first entry after the last loaded one
  assign scan_next = ({1'b0, scan_ff} + 1'b1 >= pl_count_ff) ?
                     '0 : scan_ff + 1'b1;

  // Start sources and acceptance
  logic ext_rise;
  logic start_req;
  logic start_go;
  logic idle;
  assign ext_rise = ext_s2_ff && !ext_s3_ff;
  assign start_req = wr_start || (opt_paced && pace_pulse)
                     || (opt_ext_en && ext_rise);
  assign idle = (state_ff == APS_IDLE);
  assign start_go = start_req && idle && pl_armed_ff;

  // Data FIFO hookup: tag above twelve raw bits
  logic [15:0] df_head;
  logic df_full;
  logic df_half;
  logic df_empty;
  logic df_push;
  logic df_pop;
  logic [15:0] df_wdata;
  assign df_push = adc_done && state_ff == APS_CONV;
  assign df_pop = rd_lo;
  assign df_wdata = {tag_ff, adc_data};

  aps_fifo #(
    .WIDTH(16),
    .DEPTH(DF_DEPTH)
  ) aps_fifo_i (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(ce),
    .clr(df_clr),
    .push(df_push),
    .pop(df_pop),
    .wdata(df_wdata),
    .head(df_head),
    .full(df_full),
    .half(df_half),
    .empty(df_empty)
  );

  // Status byte, FIFO flags inverted
  logic [7:0] status;
  assign status[`APS_ST_BUSY] = idle;
  assign status[`APS_ST_PL_FULL] = !pl_full;
  assign status[`APS_ST_PL_HALF] = !pl_half;
  assign status[`APS_ST_PL_EMPTY] = !pl_empty;
  assign status[`APS_ST_DF_FULL] = !df_full;
  assign status[`APS_ST_DF_HALF] = !df_half;
  assign status[`APS_ST_DF_EMPTY] = !df_empty;
  assign status[`APS_ST_EXT] = ext_s2_ff;

  // Read data selection
  logic [15:0] nxt_rdata;
  assign nxt_rdata = rd_lo ? (io_word ? df_head : {8'h00, df_head[7:0]})
                   : rd_hi ? {8'h00, df_head[15:8]}
                   : rd_pl ? pl_mem[0]
                   : rd_stat ? {8'h00, status}
                   : 16'h0000;

  // Interrupt events; a new event beats the status-read clear
  logic err_ev;
  logic irq_set;
  logic nxt_irq;
  assign err_ev = (rd_lo && df_empty) || (df_push && df_full);
  assign irq_set = (opt_half_ie && df_half)
                   || (opt_err_ie && err_ev);
  assign nxt_irq = irq_set || (irq_ff && !rd_stat);

  // Start pin synchroniser and edge history
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end
    else if (ce)
    begin
      ext_s1_ff <= ext_start_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Point-list storage writes
  always_ff @(posedge ref_clk)
  begin
    if (ce && wr_pl && !pl_full)
      pl_mem[pl_count_ff[PAW-1:0]] <= io_wdata;
  end

  // Point-list count, scan index and arming
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (ce && pl_clr))
    begin
      pl_count_ff <= '0;
      scan_ff <= '0;
      pl_armed_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_pl && !pl_full)
        pl_count_ff <= pl_count_ff + 1'b1;
      if (rd_pl)
        scan_ff <= '0;
      else if (start_go)
        scan_ff <= scan_next;
      if (wr_pl)
        pl_armed_ff <= 1'b0;
      else if (rd_pl)
        pl_armed_ff <= 1'b1;
    end
  end

  // Option register; clear bits are strobes and not kept
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      opt_ff <= `APS_OPT_RESET;
    else if (ce && wr_opt)
      opt_ff <= io_wdata[7:0] & 8'h87;
  end

  // Conversion state
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_ff <= APS_IDLE;
    else if (ce)
    begin
      unique case (state_ff)
        APS_IDLE: if (start_go) state_ff <= APS_CONV;
        APS_CONV: if (adc_done) state_ff <= APS_IDLE;
      endcase
    end
  end

  // Converter start pulse and entry fields
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      start_ff <= 1'b0;
      chan_ff <= 4'h0;
      differential_select_ff <= 1'b0;
      range_ff <= 3'h0;
      tag_ff <= 4'h0;
      gain_ff <= 3'h0;
    end
    else if (ce)
    begin
      start_ff <= start_go;
      if (start_go)
      begin
        differential_select_ff <= cur_entry[`APS_ENT_DIFFERENTIAL_SELECT];
        // Differential uses pairs 0..7, so top channel bit drops
        chan_ff <= {cur_entry[`APS_ENT_CH_HI] &
                    !cur_entry[`APS_ENT_DIFFERENTIAL_SELECT],
                    cur_entry[`APS_ENT_CH_HI-1:`APS_ENT_CH_LO]};
        range_ff <= cur_entry[`APS_ENT_RANGE_HI:`APS_ENT_RANGE_LO];
        tag_ff <= cur_entry[`APS_ENT_TAG_HI:`APS_ENT_TAG_LO];
        gain_ff <= cur_entry[`APS_ENT_GAIN_HI:`APS_ENT_GAIN_LO];
      end
    end
  end

  // Host read data and interrupt request
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdata_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end
    else if (ce)
    begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata = rdata_ff;
  assign irq = irq_ff;
  assign adc_start = start_ff;
  assign adc_channel = chan_ff;
  assign adc_differential_select = differential_select_ff;
  assign adc_range = range_ff;
  assign submux_tag = tag_ff;
  assign submux_gain = gain_ff;

  // Checks on the sequencer
  sw_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && wr_start && idle && pl_armed_ff |=> adc_start && !idle)
    else $error("software start did not begin a conversion");
  hi_byte_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && rd_hi |=> io_rdata == {8'h00, $past(df_head[15:8])})
    else $error("high result byte wrong");
  fifo_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && df_push && df_empty && !df_clr |=> df_head == $past(df_wdata))
    else $error("first result not at FIFO head");
  raw_result_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && df_push && df_empty && !df_clr
    |=> df_head[11:0] == $past(adc_data))
    else $error("result bits altered");
  pl_append_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && wr_pl && !pl_full && !pl_clr
    |=> pl_count_ff == $past(pl_count_ff) + 1'b1 && !pl_armed_ff)
    else $error("point-list append failed");
  unarmed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && !pl_armed_ff |=> !adc_start)
    else $error("conversion started before arming read");
  entry_fields_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && start_go |=> adc_range == $past(cur_entry[2:0])
    && submux_tag == $past(cur_entry[15:12])
    && submux_gain == $past(cur_entry[10:8]))
    else $error("entry fields not applied");
  differential_select_pair_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    adc_start && adc_differential_select |-> !adc_channel[3])
    else $error("differential channel out of pair range");
  df_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && df_clr |=> df_empty)
    else $error("data FIFO clear failed");
  half_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && opt_half_ie && df_half |=> irq)
    else $error("half-full interrupt missing");
  err_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && opt_err_ie && rd_lo && df_empty |=> irq)
    else $error("error interrupt missing");
  busy_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && rd_stat |=> io_rdata[7] == $past(idle)
    && io_rdata[1] == !$past(df_empty))
    else $error("status flags wrong");
  paced_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && opt_paced && pace_pulse && idle && pl_armed_ff |=> adc_start)
    else $error("paced start missed");
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && rd_stat && !irq_set |=> !irq)
    else $error("status read did not clear interrupt");
  irq_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    irq && !(ce && rd_stat) |=> irq)
    else $error("interrupt dropped without status read");
  wrap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ce && start_go && !rd_pl && !pl_clr
    && {1'b0, scan_ff} + 1'b1 >= pl_count_ff |=> scan_ff == '0)
    else $error("scan index did not wrap");

  conv_done_c: cover property (@(posedge ref_clk) adc_done && !idle);
  irq_c: cover property (@(posedge ref_clk) irq_set && !irq);
  overflow_c: cover property (@(posedge ref_clk) df_push && df_full);
  wrap_c: cover property (@(posedge ref_clk) start_go && scan_next == '0);
endmodule

//--- test/aps_adc_model.sv
/*
  Behavioural converter standing at the far side of the sequencer: takes
  each start pulse, waits a short or long latency, then returns a result.
  Assumes one clock, ref_clk, shared with the sequencer.
*/
`timescale 1ns/1ps
module aps_adc_model
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  input wire logic adc_differential_select,
  input wire logic [2:0] adc_range,
  output logic adc_done,
  output logic [11:0] adc_data
);
  logic busy_ff;
  logic [4:0] cnt_ff;
  logic [11:0] val_ff;

  // Result encodes the fields it was started with, twelve bits only
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 5'h00;
      val_ff <= 12'h000;
      adc_done <= 1'b0;
      adc_data <= 12'h5a5;
    end
    else
    begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data; // Not valid outside the done pulse
      if (busy_ff)
      begin
        if (cnt_ff == 5'h00)
        begin
          adc_done <= 1'b1;
          adc_data <= val_ff;
          busy_ff <= 1'b0;
        end
        else
          cnt_ff <= cnt_ff - 5'h01;
      end
      else if (adc_start)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= slow ? 5'h0c : 5'h01;
        val_ff <= {adc_range, adc_differential_select, adc_channel, 4'ha};
      end
    end
  end
endmodule

//--- test/aps_sequencer_tb.sv
/*
  Self-checking bench for the point-list sequencer: host I/O tasks,
  converter model, pacing and external start stimulus.
  Assumes small FIFO depths of 8 set through the parameters.
*/
`timescale 1ns/1ps
module aps_sequencer_tb;
  import aps_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, slow = 1'b1;
  logic [2:0] io_addr = 3'h0;
  logic io_wr = 1'b0, io_rd = 1'b0, io_word = 1'b0;
  logic [15:0] io_wdata = 16'h0000, io_rdata, rd;
  logic pace_pulse = 1'b0, ext_start_pin = 1'b0, adc_done, adc_start;
  logic irq, adc_differential_select, ok;
  logic [11:0] adc_data;
  logic [3:0] adc_channel, submux_tag;
  logic [2:0] adc_range, submux_gain;
  logic [15:0] pl [0:2] = '{16'h3521, 16'hc2fe, 16'h9f84};
  int error_cnt = 0, compares = 0, p = 0, k;

  always #12.5 ref_clk = ~ref_clk;

  aps_sequencer #(.PL_DEPTH(8), .DF_DEPTH(8)) aps_sequencer_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_word(io_word),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq),
    .pace_pulse(pace_pulse), .ext_start_pin(ext_start_pin),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_differential_select(adc_differential_select),
    .adc_range(adc_range), .submux_tag(submux_tag),
    .submux_gain(submux_gain));

  aps_adc_model aps_adc_model_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_differential_select(adc_differential_select), .adc_range(adc_range), .adc_done(adc_done),
    .adc_data(adc_data));

  // Channel as driven: top bit dropped for differential pairs
  function automatic logic [3:0] exp_ch(input logic [15:0] e);
    return e[3] ? {1'b0, e[6:4]} : e[7:4];
  endfunction

  // Stored word: tag over the model's twelve-bit result
  function automatic logic [15:0] exp_word(input logic [15:0] e);
    return {e[15:12], e[2:0], e[3], exp_ch(e), 4'ha};
  endfunction

  task automatic end_sim();
    $display("Checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic io_write(input logic [2:0] a, input logic w,
                          input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_word = w;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    io_wr = 1'b0;
  endtask

  task automatic io_read(input logic [2:0] a, input logic w,
                         output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_word = w;
    io_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  // Bounded wait for a start pulse from the sequencer
  task automatic wait_start(output logic got);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      if (adc_start === 1'b1)
        got = 1'b1;
      else
      begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask

  // One conversion: 0 software, 1 paced, 2 external pin
  task automatic conv(input int how);
    logic [15:0] e;
    logic [15:0] s;
    logic got;
    e = pl[p];
    p = (p + 1) % 3;
    if (how == 0)
      io_write(3'h0, 1'b0, 16'h00ff);
    else
    begin
      @(posedge ref_clk);
      #1;
      if (how == 1)
        pace_pulse = 1'b1;
      else
        ext_start_pin = 1'b1;
      @(posedge ref_clk);
      #1;
      pace_pulse = 1'b0;
    end
    wait_start(got);
    if (!got)
    begin
      error_cnt++;
      end_sim();
    end
    check("fields", {adc_channel, adc_differential_select, adc_range},
          {exp_ch(e), e[3:0]});
    check("submux", {submux_tag, submux_gain}, {e[15:12], e[10:8]});
    if (slow)
    begin
      io_read(3'h4, 1'b0, s);
      check("busy", 16'(s[7]), 16'h0000);
    end
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++)
    begin
      @(posedge ref_clk);
      #1;
      got = adc_done;
    end
    if (!got)
    begin
      error_cnt++;
      end_sim();
    end
    // Let the result land and any interrupt follow
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    io_read(3'h4, 1'b0, rd);
    check("status reset", rd, 16'h00ec);
    io_write(3'h2, 1'b0, 16'h0077);
    for (k = 0; k < 3; k++)
      io_write(3'h2, 1'b1, pl[k]);
    io_read(3'h2, 1'b1, rd);
    check("arm readback", rd, pl[0]);
    for (k = 0; k < 4; k++)
    begin
      conv(0);
      slow = 1'b0;
    end
    io_read(3'h4, 1'b0, rd);
    check("status half", rd, 16'h00fa);
    check("half irq off", 16'(irq), 16'h0000);
    for (k = 0; k < 3; k++)
    begin
      io_read(3'h0, 1'b1, rd);
      check("result word", rd, exp_word(pl[k]));
    end
    io_read(3'h1, 1'b0, rd);
    check("high byte", rd, exp_word(pl[0]) >> 8);
    io_read(3'h0, 1'b0, rd);
    check("low byte", rd, exp_word(pl[0]) & 16'h00ff);
    io_write(3'h4, 1'b0, 16'h0002);
    io_read(3'h0, 1'b1, rd);
    repeat (6) @(posedge ref_clk);
    #1;
    check("empty read irq", 16'(irq), 16'h0001);
    io_read(3'h4, 1'b0, rd);
    check("data empty", 16'(rd[3:1]), 16'h0006);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq cleared", 16'(irq), 16'h0000);
    io_write(3'h4, 1'b0, 16'h0005);
    for (k = 0; k < 4; k++)
      conv(1);
    check("half irq", 16'(irq), 16'h0001);
    for (k = 0; k < 4; k++)
      conv(1);
    io_read(3'h4, 1'b0, rd);
    check("status full", rd, 16'h00f2);
    io_write(3'h4, 1'b0, 16'h0003);
    io_read(3'h4, 1'b0, rd);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq after clear", 16'(irq), 16'h0000);
    conv(1);
    check("overflow irq", 16'(irq), 16'h0001);
    for (k = 0; k < 8; k++)
    begin
      io_read(3'h0, 1'b1, rd);
      check("paced word", rd, exp_word(pl[(k + 1) % 3]));
    end
    io_write(3'h4, 1'b0, 16'h0000);
    conv(0);
    io_write(3'h4, 1'b0, 16'h0008);
    io_read(3'h4, 1'b0, rd);
    check("data clear", 16'(rd[3:1]), 16'h0006);
    io_write(3'h4, 1'b0, 16'h0080);
    conv(2);
    io_read(3'h4, 1'b0, rd);
    check("pin state", rd & 16'h0081, 16'h0081);
    ext_start_pin = 1'b0;
    io_write(3'h4, 1'b0, 16'h0040);
    io_read(3'h4, 1'b0, rd);
    check("list clear", 16'(rd[4]), 16'h0000);
    io_write(3'h0, 1'b0, 16'h0000);
    wait_start(ok);
    check("unarmed start", 16'(ok), 16'h0000);
    for (k = 0; k < 8; k++)
      io_write(3'h2, 1'b1, 16'h0010);
    io_read(3'h4, 1'b0, rd);
    check("list full", 16'(rd[6:4]), 16'h0001);
    // Clock enable low: a list clear must not act
    ce = 1'b0;
    io_write(3'h4, 1'b0, 16'h0040);
    ce = 1'b1;
    io_read(3'h4, 1'b0, rd);
    check("ce freeze", 16'(rd[6:4]), 16'h0001);
    end_sim();
  end
endmodule
